// ### hw/sadm_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sadm_regs.svh"

module sadm_top
   import sadm_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // core request
   input  wire logic        req_valid_i,
   input  wire sadm_req_s   req_i,
   output logic             req_ready_o,
   // core response
   output logic             rsp_valid_o,
   output logic [63:0]      rsp_rdata_o,
   output logic             rsp_fault_o,
   output logic             rsp_xn_o,
   // execution of a blocked fetch
   input  wire logic        xn_exec_i,
   output logic             xn_fault_o,
   // target side
   output logic             tgt_valid_o,
   output sadm_sel_t        tgt_sel_o,
   output logic [31:0]      tgt_addr_o,
   output logic             tgt_write_o,
   output logic [3:0]       tgt_be_o,
   output logic [31:0]      tgt_wdata_o,
   output sadm_mtype_e      tgt_mtype_o,
   output logic             tgt_xn_o,
   input  wire logic        tgt_ready_i,
   input  wire logic [31:0] tgt_rdata_i,
   input  wire logic        tgt_err_i
);

   sadm_state_e state_r,     state_nxt;
   logic        ready_r,     ready_nxt;
   logic        rvalid_r,    rvalid_nxt;
   logic [63:0] rdata_r,     rdata_nxt;
   logic        rfault_r,    rfault_nxt;
   logic        rxn_r,       rxn_nxt;
   logic        xnf_r;
   logic        tvalid_r,    tvalid_nxt;
   sadm_sel_t   tsel_r,      tsel_nxt;
   logic [31:0] taddr_r,     taddr_nxt;
   logic        twrite_r,    twrite_nxt;
   logic [3:0]  tbe_r,       tbe_nxt;
   logic [31:0] twdata_r,    twdata_nxt;
   sadm_mtype_e tmtype_r,    tmtype_nxt;
   logic        txn_r,       txn_nxt;
   logic        dword_r,     dword_nxt;
   logic        beat_r,      beat_nxt;
   logic        alias_r,     alias_nxt;
   logic [4:0]  bitpos_r,    bitpos_nxt;
   logic        wbit_r,      wbit_nxt;
   logic        posted_r,    posted_nxt;
   logic        err_r,       err_nxt;
   logic [31:0] whi_r,       whi_nxt;

   sadm_attr_s  attr;
   logic [3:0]  lane_be;
   logic [31:0] lane_wd;
   logic [31:0] lane_rj;

   // decode of the full 32-bit space
   sadm_region_decode u_decode (
      .addr_i (req_i.addr),
      .fetch_i(req_i.fetch),
      .size_i (req_i.size),
      .attr_o (attr)
   );

   // lanes follow the request while idle, the held address otherwise
   wire logic        st_idle  = (state_r == SADM_ST_IDLE);
   wire logic [1:0]  lane_ofs = st_idle ? attr.tgt_addr[1:0] : taddr_r[1:0];
   wire sadm_size_e  lane_sz  = st_idle ? req_i.size : SADM_SZ_WORD;

   sadm_lane_gen u_lanes (
      .ofs_i  (lane_ofs),
      .size_i (lane_sz),
      .wdata_i(req_i.wdata[31:0]),
      .rdata_i(tgt_rdata_i),
      .be_o   (lane_be),
      .wlane_o(lane_wd),
      .rjust_o(lane_rj)
   );

   // request qualification
   wire logic        accept   = st_idle & req_valid_i & ready_r;
   wire logic        is_dword = (req_i.size == SADM_SZ_DWORD);
   // fetch from a no-execute region is never forwarded
   wire logic        blk_xn   = req_i.fetch & attr.no_execute_attr & ~attr.fault;
   // only plain device writes post; strongly ordered writes wait for the target
   wire logic        post_ok  = req_i.write & (attr.mtype == SADM_MT_DEVICE)
                             & ~attr.alias_hit & ~is_dword;
   wire logic        tgt_done = tvalid_r & tgt_ready_i;
   wire logic        err_acc  = err_r | tgt_err_i;
   // bit-band read-modify-write merge, kept to the access's own strobes
   wire logic [31:0] bit_mask = 32'h0000_0001 << bitpos_r;
   wire logic [31:0] rmw_word = wbit_r ? (tgt_rdata_i | bit_mask) : (tgt_rdata_i & ~bit_mask);
   wire logic        al_bit   = tgt_rdata_i[bitpos_r];

   // sequencer: one transfer in flight at a time
   always_comb begin
      state_nxt  = state_r;
      rvalid_nxt = 1'b0;
      rdata_nxt  = rdata_r;
      rfault_nxt = rfault_r;
      rxn_nxt    = rxn_r;
      tvalid_nxt = tvalid_r;
      tsel_nxt   = tsel_r;
      taddr_nxt  = taddr_r;
      twrite_nxt = twrite_r;
      tbe_nxt    = tbe_r;
      twdata_nxt = twdata_r;
      tmtype_nxt = tmtype_r;
      txn_nxt    = txn_r;
      dword_nxt  = dword_r;
      beat_nxt   = beat_r;
      alias_nxt  = alias_r;
      bitpos_nxt = bitpos_r;
      wbit_nxt   = wbit_r;
      posted_nxt = posted_r;
      err_nxt    = err_r;
      whi_nxt    = whi_r;
      unique case (state_r)
         SADM_ST_IDLE: begin
            if (accept) begin
               rdata_nxt  = '0;
               rfault_nxt = 1'b0;
               rxn_nxt    = 1'b0;
               if (attr.fault) begin
                  // bus fault answer, no target strobe
                  rvalid_nxt = 1'b1;
                  rfault_nxt = 1'b1;
               end else if (blk_xn) begin
                  // tag the fetch, fault only on execution
                  rvalid_nxt = 1'b1;
                  rxn_nxt    = 1'b1;
               end else begin
                  // select and attributes leave with the address
                  tvalid_nxt = 1'b1;
                  tsel_nxt   = attr.sel;
                  taddr_nxt  = attr.tgt_addr;
                  tmtype_nxt = attr.mtype;
                  txn_nxt    = attr.no_execute_attr;
                  tbe_nxt    = lane_be;
                  twdata_nxt = lane_wd;
                  twrite_nxt = req_i.write & ~attr.alias_hit;
                  dword_nxt  = is_dword;
                  beat_nxt   = 1'b0;
                  alias_nxt  = attr.alias_hit;
                  bitpos_nxt = attr.bit_pos;
                  wbit_nxt   = req_i.wdata[0];
                  whi_nxt    = req_i.wdata[63:32];
                  err_nxt    = 1'b0;
                  // posted device write answers at once
                  posted_nxt = post_ok;
                  rvalid_nxt = post_ok;
                  // alias write reads the word first
                  state_nxt  = (attr.alias_hit & req_i.write) ? SADM_ST_RDWAIT
                                                              : SADM_ST_ISSUE;
               end
            end
         end
         SADM_ST_RDWAIT: begin
            if (tgt_done) begin
               if (tgt_err_i) begin
                  tvalid_nxt = 1'b0;
                  rvalid_nxt = 1'b1;
                  rfault_nxt = 1'b1;
                  state_nxt  = SADM_ST_IDLE;
               end else begin
                  // write back with only the addressed bit changed
                  twrite_nxt = 1'b1;
                  twdata_nxt = rmw_word;
                  state_nxt  = SADM_ST_ISSUE;
               end
            end
         end
         SADM_ST_ISSUE: begin
            if (tgt_done) begin
               if (dword_r & ~beat_r) begin
                  // second word of a 64-bit transfer at the next word
                  beat_nxt         = 1'b1;
                  err_nxt          = err_acc;
                  taddr_nxt        = taddr_r + `SADM_BEAT_STEP;
                  twdata_nxt       = whi_r;
                  rdata_nxt[31:0]  = tgt_rdata_i;
               end else begin
                  // next request is taken only after completion
                  tvalid_nxt = 1'b0;
                  state_nxt  = SADM_ST_IDLE;
                  if (!posted_r) begin
                     rvalid_nxt = 1'b1;
                     rfault_nxt = err_acc;
                     if (twrite_r) begin
                        rdata_nxt = '0;
                     end else if (alias_r) begin
                        rdata_nxt = {63'h0, al_bit};
                     end else if (dword_r) begin
                        rdata_nxt = {tgt_rdata_i, rdata_r[31:0]};
                     end else begin
                        rdata_nxt = {`SADM_ZERO32, lane_rj};
                     end
                  end
               end
            end
         end
      endcase
      // ready drops while any transfer is in flight
      ready_nxt = (state_nxt == SADM_ST_IDLE);
   end

   // control and answer registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_r  <= SADM_ST_IDLE;
         ready_r  <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rfault_r <= 1'b0;
         rxn_r    <= 1'b0;
         xnf_r    <= 1'b0;
         tvalid_r <= 1'b0;
         posted_r <= 1'b0;
         err_r    <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         ready_r  <= ready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
         rfault_r <= rfault_nxt;
         rxn_r    <= rxn_nxt;
         // exception raised only when the tagged instruction executes
         xnf_r    <= xn_exec_i;
         tvalid_r <= tvalid_nxt;
         posted_r <= posted_nxt;
         err_r    <= err_nxt;
      end
   end

   // target-side address phase registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tsel_r   <= '0;
         taddr_r  <= '0;
         twrite_r <= 1'b0;
         tbe_r    <= 4'h0;
         twdata_r <= '0;
         tmtype_r <= SADM_MT_NORMAL;
         txn_r    <= 1'b0;
      end else begin
         tsel_r   <= tsel_nxt;
         taddr_r  <= taddr_nxt;
         twrite_r <= twrite_nxt;
         tbe_r    <= tbe_nxt;
         twdata_r <= twdata_nxt;
         tmtype_r <= tmtype_nxt;
         txn_r    <= txn_nxt;
      end
   end

   // transfer context
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         dword_r  <= 1'b0;
         beat_r   <= 1'b0;
         alias_r  <= 1'b0;
         bitpos_r <= 5'h00;
         wbit_r   <= 1'b0;
         whi_r    <= '0;
      end else begin
         dword_r  <= dword_nxt;
         beat_r   <= beat_nxt;
         alias_r  <= alias_nxt;
         bitpos_r <= bitpos_nxt;
         wbit_r   <= wbit_nxt;
         whi_r    <= whi_nxt;
      end
   end

   // outputs straight from flops
   assign req_ready_o = ready_r;
   assign rsp_valid_o = rvalid_r;
   assign rsp_rdata_o = rdata_r;
   assign rsp_fault_o = rfault_r;
   assign rsp_xn_o    = rxn_r;
   assign xn_fault_o  = xnf_r;
   assign tgt_valid_o = tvalid_r;
   assign tgt_sel_o   = tsel_r;
   assign tgt_addr_o  = taddr_r;
   assign tgt_write_o = twrite_r;
   assign tgt_be_o    = tbe_r;
   assign tgt_wdata_o = twdata_r;
   assign tgt_mtype_o = tmtype_r;
   assign tgt_xn_o    = txn_r;

endmodule // sadm_top
`default_nettype wire

// ### inc/sadm_regs.svh
`ifndef SADM_REGS_SVH
`define SADM_REGS_SVH

// target windows of the fixed map
`define SADM_FLASH_HI    32'h0001_FFFF
`define SADM_ROM_LO      32'h0100_0000
`define SADM_ROM_HI      32'h1FFF_FFFF
`define SADM_SRAM_LO     32'h2000_0000
`define SADM_SRAM_HI     32'h2000_7FFF
`define SADM_SAL_LO      32'h2200_0000
`define SADM_SAL_HI      32'h220F_FFFF
`define SADM_PERI_LO     32'h4000_0000
`define SADM_PERI_HI     32'h400F_FFFF
`define SADM_PAL_LO      32'h4200_0000
`define SADM_PAL_HI      32'h43FF_FFFF
`define SADM_DBG_LO      32'hE000_0000
`define SADM_DBG_HI      32'hE000_2FFF
`define SADM_CORE_LO     32'hE000_E000
`define SADM_CORE_HI     32'hE000_EFFF
`define SADM_TRACE_PORT_UNIT_LO     32'hE004_0000
`define SADM_TRACE_PORT_UNIT_HI     32'hE004_0FFF

// region type boundaries
`define SADM_SRAMREG_HI  32'h3FFF_FFFF
`define SADM_PERIREG_HI  32'h5FFF_FFFF

// one-hot target select positions
`define SADM_T_FLASH     0
`define SADM_T_ROM       1
`define SADM_T_SRAM      2
`define SADM_T_PERI      3
`define SADM_T_CORE      4
`define SADM_T_DBG       5

// alias arithmetic and beat step
`define SADM_AL_BYTE_HI  24
`define SADM_AL_BYTE_LO  5
`define SADM_AL_BIT_HI   4
`define SADM_AL_BIT_LO   2
`define SADM_AL_PAD      12'h000
`define SADM_BEAT_STEP   32'h0000_0004
`define SADM_ZERO32      32'h0000_0000

`endif

// ### inc/sadm_pkg.sv
`default_nettype none

package sadm_pkg;

   typedef enum logic [1:0] {
      SADM_SZ_BYTE  = 2'h0,
      SADM_SZ_HALF  = 2'h1,
      SADM_SZ_WORD  = 2'h2,
      SADM_SZ_DWORD = 2'h3
   } sadm_size_e;

   typedef enum logic [1:0] {
      SADM_MT_NORMAL = 2'h0,
      SADM_MT_DEVICE = 2'h1,
      SADM_MT_STRONG = 2'h2
   } sadm_mtype_e;

   typedef enum logic [2:0] {
      SADM_ST_IDLE   = 3'h1,
      SADM_ST_RDWAIT = 3'h2,
      SADM_ST_ISSUE  = 3'h4
   } sadm_state_e;

   typedef logic [5:0] sadm_sel_t;

   typedef struct packed {
      logic [31:0] addr;
      logic        write;
      logic        fetch;
      sadm_size_e  size;
      logic [63:0] wdata;
   } sadm_req_s;

   typedef struct packed {
      sadm_sel_t   sel;
      sadm_mtype_e mtype;
      logic        no_execute_attr;
      logic        fault;
      logic        alias_hit;
      logic [31:0] tgt_addr;
      logic [4:0]  bit_pos;
   } sadm_attr_s;

endpackage

`default_nettype wire

// ### hw/sadm_region_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "sadm_regs.svh"

module sadm_region_decode
   import sadm_pkg::*;
(
   // access address phase
   input  wire logic [31:0] addr_i,
   input  wire logic        fetch_i,
   input  wire sadm_size_e  size_i,
   // region attributes
   output sadm_attr_s       attr_o
);

   // window hits
   // flash and boot rom
   wire logic        hit_flash = (addr_i <= `SADM_FLASH_HI);
   wire logic        hit_rom   = (addr_i >= `SADM_ROM_LO)  && (addr_i <= `SADM_ROM_HI);
   wire logic        hit_sram  = (addr_i >= `SADM_SRAM_LO) && (addr_i <= `SADM_SRAM_HI);
   wire logic        hit_sal   = (addr_i >= `SADM_SAL_LO)  && (addr_i <= `SADM_SAL_HI);
   wire logic        hit_peri  = (addr_i >= `SADM_PERI_LO) && (addr_i <= `SADM_PERI_HI);
   wire logic        hit_pal   = (addr_i >= `SADM_PAL_LO)  && (addr_i <= `SADM_PAL_HI);
   wire logic        hit_core  = (addr_i >= `SADM_CORE_LO) && (addr_i <= `SADM_CORE_HI);
   wire logic        hit_dbg   = ((addr_i >= `SADM_DBG_LO) && (addr_i <= `SADM_DBG_HI))
                              || ((addr_i >= `SADM_TRACE_PORT_UNIT_LO) && (addr_i <= `SADM_TRACE_PORT_UNIT_HI));
   wire logic        hit_alias = hit_sal | hit_pal;

   // alias word to bit-band byte: byte = alias offset / 32, bit = offset[4:2]
   wire logic [31:0] al_base   = hit_sal ? `SADM_SAL_LO : `SADM_PAL_LO;
   wire logic [31:0] bb_base   = hit_sal ? `SADM_SRAM_LO : `SADM_PERI_LO;
   wire logic [31:0] al_ofs    = addr_i - al_base;
   wire logic [31:0] bb_addr   = bb_base
                              + {`SADM_AL_PAD, al_ofs[`SADM_AL_BYTE_HI:`SADM_AL_BYTE_LO]};
   // access size carries through to the underlying location
   wire logic [31:0] bb_align  = (size_i == SADM_SZ_BYTE) ? bb_addr :
                                 (size_i == SADM_SZ_HALF) ? {bb_addr[31:1], 1'b0} :
                                                            {bb_addr[31:2], 2'b00};

   wire sadm_sel_t   sel_raw;
   assign sel_raw[`SADM_T_FLASH] = hit_flash;
   assign sel_raw[`SADM_T_ROM]   = hit_rom;
   assign sel_raw[`SADM_T_SRAM]  = hit_sram | hit_sal;
   assign sel_raw[`SADM_T_PERI]  = hit_peri | hit_pal;
   assign sel_raw[`SADM_T_CORE]  = hit_core;
   assign sel_raw[`SADM_T_DBG]   = hit_dbg;

   // reserved gaps fault; alias fetches and dword aliases have no target either
   wire logic        fault_w   = ~(|sel_raw) | (hit_alias & fetch_i)
                              | (hit_alias & (size_i == SADM_SZ_DWORD));

   wire sadm_mtype_e mtype_w   = (addr_i <= `SADM_SRAMREG_HI) ? SADM_MT_NORMAL :
                                 (addr_i <= `SADM_PERIREG_HI) ? SADM_MT_DEVICE :
                                                                SADM_MT_STRONG;

   assign attr_o.sel             = fault_w ? '0 : sel_raw;
   assign attr_o.mtype           = mtype_w;
   assign attr_o.no_execute_attr = (addr_i > `SADM_SRAMREG_HI);
   assign attr_o.fault           = fault_w;
   assign attr_o.alias_hit       = hit_alias;
   assign attr_o.tgt_addr        = hit_alias ? bb_align : addr_i;
   assign attr_o.bit_pos         = {bb_addr[1:0], al_ofs[`SADM_AL_BIT_HI:`SADM_AL_BIT_LO]};

endmodule // sadm_region_decode
`default_nettype wire

// ### hw/sadm_lane_gen.sv
`timescale 1ns/10ps
`default_nettype none

module sadm_lane_gen
   import sadm_pkg::*;
(
   // access shape
   input  wire logic [1:0]  ofs_i,
   input  wire sadm_size_e  size_i,
   // data in
   input  wire logic [31:0] wdata_i,
   input  wire logic [31:0] rdata_i,
   // lanes out
   output logic [3:0]       be_o,
   output logic [31:0]      wlane_o,
   output logic [31:0]      rjust_o
);

   // little endian: byte k of a word rides lane k
   wire logic [4:0] shamt = {ofs_i, 3'b000};

   // byte, halfword and word strobes; a dword beat is a full word
   assign be_o    = (size_i == SADM_SZ_BYTE) ? (4'h1 << ofs_i) :
                    (size_i == SADM_SZ_HALF) ? (4'h3 << ofs_i) : 4'hF;
   assign wlane_o = wdata_i << shamt;
   assign rjust_o = rdata_i >> shamt;

endmodule // sadm_lane_gen
`default_nettype wire

// ### bench/sadm_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sadm_top_asserts
   import sadm_pkg::*;
(
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // core side
   input  wire logic        req_valid_i,
   input  wire sadm_req_s   req_i,
   input  wire logic        req_ready_o,
   input  wire logic        rsp_valid_o,
   input  wire logic        rsp_fault_o,
   input  wire logic        rsp_xn_o,
   input  wire logic        xn_exec_i,
   input  wire logic        xn_fault_o,
   // target side
   input  wire logic        tgt_valid_o,
   input  wire sadm_sel_t   tgt_sel_o,
   input  wire logic [31:0] tgt_addr_o,
   input  wire logic        tgt_write_o,
   input  wire sadm_mtype_e tgt_mtype_o,
   input  wire logic        tgt_xn_o,
   input  wire logic        tgt_ready_i
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // whole 256 MB slices that are reserved from end to end
   wire take = req_valid_i && req_ready_o;
   wire hole = (req_i.addr[31:28] >= 4'h6 && req_i.addr[31:28] <= 4'hD)
            || req_i.addr[31:28] == 4'hF;
   wire peri = req_i.addr[31:20] == 12'h400;

   chk_hole_fault: assert property (
      take && hole |=> rsp_valid_o && rsp_fault_o && !tgt_valid_o)
      else $error("reserved access not faulted");
   chk_xn_block: assert property (
      take && req_i.fetch && peri |=> rsp_xn_o && !tgt_valid_o && !xn_fault_o)
      else $error("fetch from no-execute region forwarded");
   chk_exec_fault: assert property (xn_exec_i |=> xn_fault_o)
      else $error("executed blocked fetch gave no fault");
   chk_type_map: assert property (
      tgt_valid_o |-> tgt_mtype_o == (tgt_addr_o < 32'h4000_0000 ? SADM_MT_NORMAL :
      tgt_addr_o < 32'h6000_0000 ? SADM_MT_DEVICE : SADM_MT_STRONG))
      else $error("memory type wrong for region");
   chk_xn_attr: assert property (tgt_valid_o |-> tgt_xn_o == (tgt_addr_o[31:30] != 2'h0))
      else $error("no-execute flag wrong for region");
   chk_core_sel: assert property (
      tgt_valid_o && tgt_addr_o[31:12] == 20'hE000E |-> tgt_sel_o == 6'h10)
      else $error("core block not selected");
   chk_sram_sel: assert property (
      tgt_valid_o && tgt_addr_o[31:15] == 17'h04000 |-> tgt_sel_o == 6'h04)
      else $error("sram not selected");
   chk_tgt_hold: assert property (
      tgt_valid_o && !tgt_ready_i |=> tgt_valid_o && $stable(tgt_addr_o) && $stable(tgt_sel_o))
      else $error("target request changed before accept");
   chk_one_flight: assert property (tgt_valid_o |-> !req_ready_o)
      else $error("new request accepted during target access");
   chk_strong_wr: assert property (
      tgt_valid_o && tgt_write_o && tgt_mtype_o == SADM_MT_STRONG |-> !rsp_valid_o)
      else $error("strongly ordered write answered early");
endmodule // sadm_top_asserts

bind sadm_top sadm_top_asserts u_chk (.mclk_i, .rst_n_i, .req_valid_i, .req_i, .req_ready_o,
   .rsp_valid_o, .rsp_fault_o, .rsp_xn_o, .xn_exec_i, .xn_fault_o, .tgt_valid_o, .tgt_sel_o,
   .tgt_addr_o, .tgt_write_o, .tgt_mtype_o, .tgt_xn_o, .tgt_ready_i);

`default_nettype wire

// ### bench/sadm_tgt_model.sv
`timescale 1ns/10ps
`default_nettype none

module sadm_tgt_model (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // access from the decoder
   input  wire logic        valid_i,
   input  wire logic [31:0] addr_i,
   input  wire logic        write_i,
   input  wire logic [3:0]  be_i,
   input  wire logic [31:0] wdata_i,
   // behaviour knobs
   input  wire logic [3:0]  wait_i,
   input  wire logic        err_i,
   // answer
   output logic             ready_o,
   output logic [31:0]      rdata_o = 32'h0,
   output logic             err_o
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] cur, wa;
   logic [3:0]  cnt_r;

   // unwritten words read as inverted address; idle data toggles so stale data never matches
   always @(posedge mclk_i) begin
      ready_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (!rst_n_i) begin
         cnt_r <= 4'h0;
      end else if (valid_i && !ready_o) begin
         if (cnt_r >= wait_i) begin
            wa = {addr_i[31:2], 2'h0};
            cur = mem.exists(wa) ? mem[wa] : ~wa;
            for (int i = 0; i < 4; i++) if (write_i && be_i[i]) cur[8*i+:8] = wdata_i[8*i+:8];
            if (write_i) mem[wa] = cur;
            rdata_o <= cur;
            ready_o <= 1'b1;
            err_o <= err_i;
            cnt_r <= 4'h0;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule // sadm_tgt_model

`default_nettype wire

// ### bench/system_address_map_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
   $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end

module system_address_map_decoder_tb;
   import sadm_pkg::*;
   logic        mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, xn_exec = 1'b0, err_en = 1'b0;
   logic        rdy, rsp_v, rsp_f, rsp_x, xn_f, t_valid, t_write, t_xn, t_rdy, t_err, h_xn;
   logic [63:0] rdata, r_data;
   logic [31:0] t_addr, t_wdata, t_rdata, h_addr, h_wdata;
   logic [3:0]  t_be, h_be, t_wait = 4'h0;
   logic        r_fault, r_xn, h_write;
   sadm_req_s   req = '0;
   sadm_sel_t   t_sel, h_sel;
   sadm_mtype_e t_mt, h_mt;
   int          errors = 0, samples_checked = 0, hs = 0, hs0;

   always #2.5 mclk = ~mclk;

   sadm_top DUT (.mclk_i(mclk), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_i(req),
      .req_ready_o(rdy), .rsp_valid_o(rsp_v), .rsp_rdata_o(rdata), .rsp_fault_o(rsp_f),
      .rsp_xn_o(rsp_x), .xn_exec_i(xn_exec), .xn_fault_o(xn_f), .tgt_valid_o(t_valid),
      .tgt_sel_o(t_sel), .tgt_addr_o(t_addr), .tgt_write_o(t_write), .tgt_be_o(t_be),
      .tgt_wdata_o(t_wdata), .tgt_mtype_o(t_mt), .tgt_xn_o(t_xn), .tgt_ready_i(t_rdy),
      .tgt_rdata_i(t_rdata), .tgt_err_i(t_err));

   sadm_tgt_model u_tgt (.mclk_i(mclk), .rst_n_i(rst_n), .valid_i(t_valid), .addr_i(t_addr),
      .write_i(t_write), .be_i(t_be), .wdata_i(t_wdata), .wait_i(t_wait), .err_i(err_en),
      .ready_o(t_rdy), .rdata_o(t_rdata), .err_o(t_err));

   // record each finished target beat; the enum is copied on its own, not through a concat
   always @(posedge mclk) if (t_valid && t_rdy) begin
      hs++;
      {h_addr, h_wdata, h_sel} = {t_addr, t_wdata, t_sel};
      {h_xn, h_be, h_write} = {t_xn, t_be, t_write};
      h_mt = t_mt;
   end

   task automatic close_out;
      if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic acc(input logic [31:0] a, input logic w, f, input sadm_size_e s,
                      input logic [63:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= '{a, w, f, s, d};
      do begin @(negedge mclk); n++; end while (!rdy && n < 99);
      @(posedge mclk);
      req_valid <= 1'b0;
      do begin @(negedge mclk); n++; end while (!rsp_v && n < 199);
      if (n >= 199) begin
         errors++;
         close_out();
      end else begin
         {r_data, r_fault, r_xn} = {rdata, rsp_f, rsp_x};
      end
   endtask

   task automatic s_map;
      logic [31:0] a [6] = '{32'h0000_0100, 32'h0100_0000, 32'h2000_7FFC, 32'h400F_FFFC,
                             32'hE000_E010, 32'hE000_1000};
      sadm_sel_t   s [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
      logic [1:0]  m [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2};
      for (int i = 0; i < 6; i++) begin
         acc(a[i], 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
         `CHK(r_fault, 1'b0);
         `CHK(r_data, {32'h0, ~a[i]});
         `CHK(h_sel, s[i]);
         `CHK(h_mt, m[i]);
         `CHK({h_write, h_xn}, {1'b0, (i >= 3)});
      end
   endtask

   task automatic s_fault;
      logic [31:0] a [8] = '{32'h0002_0000, 32'h2000_8000, 32'h2210_0000, 32'h4010_0000,
                             32'h4400_0000, 32'hE000_3000, 32'hE010_0000, 32'h6000_0000};
      for (int i = 0; i < 8; i++) begin
         hs0 = hs;
         acc(a[i], i[0], 1'b0, SADM_SZ_WORD, 64'h1);
         `CHK(r_fault, 1'b1);
         `CHK(hs, hs0);
      end
      err_en = 1'b1;
      acc(32'h4000_8000, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK(r_fault, 1'b1);
      err_en = 1'b0;
   endtask

   task automatic s_xn;
      hs0 = hs;
      acc(32'h4000_0000, 1'b0, 1'b1, SADM_SZ_WORD, 64'h0);
      `CHK({r_xn, r_fault, xn_f}, 3'b100);
      `CHK(hs, hs0);
      @(posedge mclk) xn_exec <= 1'b1;
      @(posedge mclk) xn_exec <= 1'b0;
      @(negedge mclk);
      `CHK(xn_f, 1'b1);
      acc(32'h0000_0200, 1'b0, 1'b1, SADM_SZ_WORD, 64'h0);
      `CHK({r_xn, r_data}, {1'b0, 32'h0, ~32'h200});
      acc(32'h2000_0100, 1'b0, 1'b1, SADM_SZ_WORD, 64'h0);
      `CHK(r_xn, 1'b0);
   endtask

   task automatic s_lanes;
      acc(32'h2000_0003, 1'b1, 1'b0, SADM_SZ_BYTE, 64'hA5);
      `CHK({h_write, h_be, h_wdata[31:24]}, 13'h18A5);
      acc(32'h2000_0000, 1'b1, 1'b0, SADM_SZ_HALF, 64'hBEEF);
      `CHK({h_be, h_wdata[15:0]}, 20'h3BEEF);
      acc(32'h2000_0000, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK(r_data, 64'hA5FF_BEEF);
      acc(32'h2000_0003, 1'b0, 1'b0, SADM_SZ_BYTE, 64'h0);
      `CHK(r_data, 64'hA5);
      acc(32'h2000_0002, 1'b0, 1'b0, SADM_SZ_HALF, 64'h0);
      `CHK(r_data, 64'hA5FF);
      acc(32'h2000_0010, 1'b1, 1'b0, SADM_SZ_DWORD, 64'h1122_3344_5566_7788);
      `CHK(h_addr, 32'h2000_0014);
      acc(32'h2000_0010, 1'b0, 1'b0, SADM_SZ_DWORD, 64'h0);
      `CHK(r_data, 64'h1122_3344_5566_7788);
   endtask

   task automatic s_alias;
      acc(32'h2200_0208, 1'b1, 1'b0, SADM_SZ_WORD, 64'h1);
      `CHK(r_fault, 1'b0);
      `CHK({h_write, h_addr, h_be}, {1'b1, 32'h2000_0010, 4'hF});
      acc(32'h2200_0208, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK(r_data, 64'h1);
      acc(32'h2000_0010, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK(r_data, 64'h5566_778C);
      acc(32'h4200_0000, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK({h_sel, h_addr, r_data}, {6'h08, 32'h4000_0000, 64'h1});
      acc(32'h2200_0000, 1'b0, 1'b1, SADM_SZ_WORD, 64'h0);
      `CHK(r_fault, 1'b1);
      acc(32'h2200_0000, 1'b0, 1'b0, SADM_SZ_DWORD, 64'h0);
      `CHK(r_fault, 1'b1);
   endtask

   task automatic s_order;
      t_wait = 4'h5;
      hs0 = hs;
      acc(32'hE000_E010, 1'b1, 1'b0, SADM_SZ_WORD, 64'h5A);
      `CHK(hs, hs0 + 1);
      acc(32'h4000_0004, 1'b1, 1'b0, SADM_SZ_WORD, 64'h77);
      `CHK(hs, hs0 + 1);
      acc(32'h4000_0004, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK(r_data, 64'h77);
      acc(32'h2000_0010, 1'b0, 1'b0, SADM_SZ_WORD, 64'h0);
      `CHK(r_data, 64'h5566_778C);
      t_wait = 4'h0;
   endtask

   // reset, then one pass over every scenario
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      s_map();
      s_fault();
      s_xn();
      s_lanes();
      s_alias();
      s_order();
      close_out();
   end
endmodule // system_address_map_decoder_tb

`default_nettype wire
